// ===== clk_mgr_pkg.sv
// Register map, field layout and timing constants of the clock manager
package clk_mgr_pkg;

    // Register byte offsets
    localparam logic [4:0] ADDR_OSC_CTRL = 5'h00;
    localparam logic [4:0] ADDR_PLL_CFG = 5'h04;
    localparam logic [4:0] ADDR_MCK_CFG = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_INT_STATUS = 5'h10;
    localparam logic [4:0] ADDR_INT_MASK = 5'h14;

    // Oscillator control fields
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_CNT_LSB = 8;
    localparam int OSC_CNT_W = 8;
    localparam logic [31:0] OSC_CTRL_MASK = 32'h0000ff01;

    // PLL configuration fields
    localparam int PLL_DIV_LSB = 0;
    localparam int PLL_DIV_W = 8;
    localparam int PLL_CNT_LSB = 8;
    localparam int PLL_CNT_W = 6;
    localparam int PLL_MUL_LSB = 16;
    localparam int PLL_MUL_W = 11;
    localparam logic [31:0] PLL_CFG_MASK = 32'h07ff3fff;

    // Master clock fields
    localparam int MCK_SRC_LSB = 0;
    localparam int MCK_SRC_W = 2;
    localparam int MCK_CLOCK_PRESCALER_FIELD_LSB = 2;
    localparam int MCK_CLOCK_PRESCALER_FIELD_W = 3;
    localparam logic [31:0] MCK_CFG_MASK = 32'h0000001f;
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLL = 2'h2;

    // Status and interrupt bits, shared layout
    localparam int ST_OSC_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_MASTER_CLOCK_READY_FLAG_BIT = 3;
    localparam logic [31:0] INT_BITS_MASK = 32'h0000000b;

    // Reset values
    localparam logic [31:0] OSC_CTRL_RST = 32'h00000000;
    localparam logic [31:0] PLL_CFG_RST = 32'h00000000;
    localparam logic [31:0] MCK_CFG_RST = 32'h00000000;
    localparam logic [31:0] INT_MASK_RST = 32'h00000000;

    // Timing
    localparam int CLK_SYS_HZ = 125000000;
    localparam int SLOW_CLK_HZ = 32768;
    localparam int SLOW_TICK_CYCLES = CLK_SYS_HZ / SLOW_CLK_HZ;
    localparam int OSC_UNIT_SLOW_CYCLES = 8;
    localparam int PLL_UNIT_SLOW_CYCLES = 1;
    localparam int SLOW_CLK_KHZ = 32;
    localparam int MAIN_OSC_KHZ = 18432;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT_SRC,
        SW_SYNC_OLD,
        SW_SYNC_NEW
    } sw_state_t;

endpackage : clk_mgr_pkg

// ===== clk_startup_timer.sv
// Startup interval counter timed by the slow clock tick
`timescale 1ns/100ps
module clk_startup_timer #(
    parameter int CNT_W = 8,
    parameter int UNIT_TICKS = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Control
    input wire logic i_enable,
    input wire logic i_start,
    input wire logic i_tick,
    input wire logic [CNT_W-1:0] i_count,
    // Result
    output logic o_done
);
    localparam int SUB_W = (UNIT_TICKS > 1) ? $clog2(UNIT_TICKS) : 1;

    logic [CNT_W-1:0] remain;
    logic [SUB_W-1:0] sub;
    logic running;

    wire last_sub = (sub == SUB_W'(UNIT_TICKS - 1));
    wire last_unit = (remain == CNT_W'(1));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_enable) begin
            remain <= '0;
            sub <= '0;
            running <= 1'b0;
            o_done <= 1'b0;
        end else if (i_start) begin
            remain <= i_count;
            sub <= '0;
            running <= (i_count != '0);
            o_done <= (i_count == '0);
        end else if (running && i_tick) begin
            if (last_sub) begin
                sub <= '0;
                remain <= remain - CNT_W'(1);
                if (last_unit) begin
                    running <= 1'b0;
                    o_done <= 1'b1;
                end
            end else begin
                sub <= sub + SUB_W'(1);
            end
        end
    end

endmodule : clk_startup_timer

// ===== clk_manager.sv
// Clock manager: oscillator and PLL startup, master clock selection, Avalon-MM registers
//
// Functional notes
// - After reset the master clock runs from the 32 kHz slow clock until software picks another.
// - Writing the oscillator control with the enable bit set starts the oscillator and its timer.
// - The oscillator-stable flag stays clear until the startup interval has run out, then sets.
// - One startup count unit is eight slow clock periods, so stable rises after count times eight.
// - The source select can switch to the main oscillator, best done once it is stable.
// - The PLL divides its input by the low divider field, then multiplies by multiplier plus one.
// - After a PLL configuration write the lock flag sets once the PLL startup count expires.
// - Each master clock write clears the ready flag, which sets again once the setting applies.
`timescale 1ns/100ps
module clk_manager
    import clk_mgr_pkg::*;
#(
    parameter int TICK_CYCLES = SLOW_TICK_CYCLES,
    parameter int OSC_KHZ = MAIN_OSC_KHZ
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [4:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Clock controls
    output logic o_osc_enable,
    output logic o_pll_enable,
    output logic [PLL_DIV_W-1:0] o_pll_div,
    output logic [PLL_MUL_W-1:0] o_pll_mul,
    output logic [MCK_SRC_W-1:0] o_mck_source,
    output logic [MCK_CLOCK_PRESCALER_FIELD_W-1:0] o_mck_prescaler,
    output logic [31:0] o_mck_khz,
    // Interrupt
    output logic o_irq
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // Register images
    logic [31:0] osc_ctrl;
    logic [31:0] pll_cfg;
    logic [31:0] mck_cfg;
    logic [31:0] int_status;
    logic [31:0] int_mask;

    logic [TICK_W-1:0] tick_cnt;
    logic slow_tick;
    logic osc_start;
    logic pll_start;
    logic osc_stable;
    logic pll_lock;
    logic mck_ready;
    logic osc_stable_d;
    logic pll_lock_d;
    logic mck_ready_d;
    sw_state_t sw_state;

    // Bus decode
    wire req = i_read || i_write;
    wire accept = req && !o_waitrequest;
    wire wr_acc = accept && i_write;
    wire hit_osc = (i_address == ADDR_OSC_CTRL);
    wire hit_pll = (i_address == ADDR_PLL_CFG);
    wire hit_mck = (i_address == ADDR_MCK_CFG);
    wire hit_stat = (i_address == ADDR_STATUS);
    wire hit_ist = (i_address == ADDR_INT_STATUS);
    wire hit_imask = (i_address == ADDR_INT_MASK);
    wire [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                           {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    wire [31:0] wdata_m = i_writedata & be_mask;
    wire wr_osc = wr_acc && hit_osc;
    wire wr_pll = wr_acc && hit_pll;
    wire wr_mck = wr_acc && hit_mck;
    wire wr_ist = wr_acc && hit_ist;
    wire wr_imask = wr_acc && hit_imask;

    wire [31:0] next_osc_ctrl = ((osc_ctrl & ~be_mask) | wdata_m) & OSC_CTRL_MASK;
    wire [31:0] next_pll_cfg = ((pll_cfg & ~be_mask) | wdata_m) & PLL_CFG_MASK;
    wire [31:0] next_mck_cfg = ((mck_cfg & ~be_mask) | wdata_m) & MCK_CFG_MASK;
    wire [31:0] next_int_mask = ((int_mask & ~be_mask) | wdata_m) & INT_BITS_MASK;

    // Fields
    wire osc_en = osc_ctrl[OSC_EN_BIT];
    wire [OSC_CNT_W-1:0] osc_cnt = osc_ctrl[OSC_CNT_LSB +: OSC_CNT_W];
    wire [PLL_DIV_W-1:0] pll_div = pll_cfg[PLL_DIV_LSB +: PLL_DIV_W];
    wire [PLL_CNT_W-1:0] pll_cnt = pll_cfg[PLL_CNT_LSB +: PLL_CNT_W];
    wire [PLL_MUL_W-1:0] pll_mul = pll_cfg[PLL_MUL_LSB +: PLL_MUL_W];
    wire [MCK_SRC_W-1:0] req_src = mck_cfg[MCK_SRC_LSB +: MCK_SRC_W];
    wire [MCK_CLOCK_PRESCALER_FIELD_W-1:0] req_clock_prescaler_field = mck_cfg[MCK_CLOCK_PRESCALER_FIELD_LSB +: MCK_CLOCK_PRESCALER_FIELD_W];
    // A zero divider leaves the PLL switched off
    wire pll_on = (pll_div != '0);

    // Status words
    wire [31:0] status_word = (32'(osc_stable) << ST_OSC_BIT) | (32'(pll_lock) << ST_LOCK_BIT)
                            | (32'(mck_ready) << ST_MASTER_CLOCK_READY_FLAG_BIT);
    wire [31:0] events = (32'(osc_stable && !osc_stable_d) << ST_OSC_BIT)
                       | (32'(pll_lock && !pll_lock_d) << ST_LOCK_BIT)
                       | (32'(mck_ready && !mck_ready_d) << ST_MASTER_CLOCK_READY_FLAG_BIT);
    wire [31:0] ist_clear = wr_ist ? wdata_m : 32'h0;
    // Set wins over a simultaneous write-one clear
    wire [31:0] next_int_status = ((int_status & ~ist_clear) | events) & INT_BITS_MASK;

    wire [31:0] read_value = hit_osc ? osc_ctrl :
                             hit_pll ? pll_cfg :
                             hit_mck ? mck_cfg :
                             hit_stat ? status_word :
                             hit_ist ? int_status :
                             hit_imask ? int_mask : 32'h0;

    // Frequency model: divide first, then multiply
    wire [31:0] pll_in_khz = pll_on ? (32'(OSC_KHZ) / 32'(pll_div)) : 32'h0;
    wire [31:0] pll_out_khz = 32'(pll_in_khz * (32'(pll_mul) + 32'h1));
    wire [31:0] req_src_khz = (req_src == SRC_SLOW) ? 32'(SLOW_CLK_KHZ) :
                              (req_src == SRC_MAIN) ? 32'(OSC_KHZ) : pll_out_khz;
    wire src_running = (req_src == SRC_SLOW) ||
                       ((req_src == SRC_MAIN) && osc_stable) ||
                       ((req_src != SRC_SLOW) && (req_src != SRC_MAIN) && pll_lock);
    wire sw_apply = (sw_state == SW_SYNC_NEW) && slow_tick && !wr_mck;

    // Avalon slave: one wait cycle, then the answer
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0;
        end else begin
            o_waitrequest <= !(req && o_waitrequest);
            if (req && o_waitrequest) begin
                o_readdata <= i_read ? read_value : 32'h0;
            end
        end
    end

    // Software registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            osc_ctrl <= OSC_CTRL_RST;
            pll_cfg <= PLL_CFG_RST;
            mck_cfg <= MCK_CFG_RST;
            int_mask <= INT_MASK_RST;
            int_status <= 32'h0;
            osc_start <= 1'b0;
            pll_start <= 1'b0;
        end else begin
            if (wr_osc) begin
                osc_ctrl <= next_osc_ctrl;
            end
            if (wr_pll) begin
                pll_cfg <= next_pll_cfg;
            end
            if (wr_mck) begin
                mck_cfg <= next_mck_cfg;
            end
            if (wr_imask) begin
                int_mask <= next_int_mask;
            end
            int_status <= next_int_status;
            osc_start <= wr_osc && next_osc_ctrl[OSC_EN_BIT];
            pll_start <= wr_pll;
        end
    end

    // Slow clock time base
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tick_cnt <= '0;
            slow_tick <= 1'b0;
        end else begin
            slow_tick <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TICK_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt + TICK_W'(1);
        end
    end

    // Oscillator startup: each count unit is eight slow periods
    clk_startup_timer #(
        .CNT_W(OSC_CNT_W),
        .UNIT_TICKS(OSC_UNIT_SLOW_CYCLES)
    ) u_osc_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(osc_en),
        .i_start(osc_start),
        .i_tick(slow_tick),
        .i_count(osc_cnt),
        .o_done(osc_stable)
    );

    // PLL startup: each count unit is one slow period
    clk_startup_timer #(
        .CNT_W(PLL_CNT_W),
        .UNIT_TICKS(PLL_UNIT_SLOW_CYCLES)
    ) u_pll_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(pll_on),
        .i_start(pll_start),
        .i_tick(slow_tick),
        .i_count(pll_cnt),
        .o_done(pll_lock)
    );

    // Master clock switch sequencer; a write mid-switch restarts it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sw_state <= SW_IDLE;
            mck_ready <= 1'b1;
            o_mck_source <= SRC_SLOW;
            o_mck_prescaler <= '0;
            o_mck_khz <= 32'(SLOW_CLK_KHZ);
        end else if (wr_mck) begin
            sw_state <= SW_WAIT_SRC;
            mck_ready <= 1'b0;
        end else begin
            case (sw_state)
                SW_IDLE: begin
                    sw_state <= SW_IDLE;
                end
                SW_WAIT_SRC: begin
                    // Never hand over to a source that is not yet running
                    if (src_running) begin
                        sw_state <= SW_SYNC_OLD;
                    end
                end
                SW_SYNC_OLD: begin
                    if (slow_tick) begin
                        sw_state <= SW_SYNC_NEW;
                    end
                end
                SW_SYNC_NEW: begin
                    if (slow_tick) begin
                        sw_state <= SW_IDLE;
                        mck_ready <= 1'b1;
                        o_mck_source <= req_src;
                        o_mck_prescaler <= req_clock_prescaler_field;
                        o_mck_khz <= req_src_khz >> req_clock_prescaler_field;
                    end
                end
                default: begin
                    sw_state <= SW_IDLE;
                end
            endcase
        end
    end

    // Flag history and outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            osc_stable_d <= 1'b0;
            pll_lock_d <= 1'b0;
            mck_ready_d <= 1'b1;
            o_irq <= 1'b0;
            o_osc_enable <= 1'b0;
            o_pll_enable <= 1'b0;
            o_pll_div <= '0;
            o_pll_mul <= '0;
        end else begin
            osc_stable_d <= osc_stable;
            pll_lock_d <= pll_lock;
            mck_ready_d <= mck_ready;
            o_irq <= |(next_int_status & int_mask);
            o_osc_enable <= osc_en;
            o_pll_enable <= pll_on;
            o_pll_div <= pll_div;
            o_pll_mul <= pll_mul;
        end
    end

    // Helper: slow ticks seen from the last oscillator start until the stable flag sets
    logic [11:0] osc_ticks_seen;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || osc_start) begin
            osc_ticks_seen <= 12'h0;
        end else if (slow_tick && !osc_stable) begin
            osc_ticks_seen <= osc_ticks_seen + 12'h1;
        end
    end

    a_reset_slow_src: assert property (@(posedge i_clk_sys)
        $fell(i_rst) |-> (o_mck_source == SRC_SLOW) && mck_ready)
        else $error("master clock not on slow clock after reset");

    a_osc_start_write: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (wr_osc && wdata_m[OSC_EN_BIT]) |=> osc_start ##1 o_osc_enable
            && (osc_stable == (osc_cnt == '0)))
        else $error("oscillator write did not start the oscillator");

    a_osc_stable_late: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        osc_start |=> (osc_stable == (osc_cnt == '0)) [*2])
        else $error("oscillator stable flag set before startup elapsed");

    a_osc_eight_units: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(osc_stable) |-> (osc_ticks_seen == {1'b0, osc_cnt, 3'b000}))
        else $error("oscillator startup length is not count times eight");

    a_pll_div_mul: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pll_on |-> (pll_in_khz * 32'(pll_div) <= 32'(OSC_KHZ))
            && ((32'(OSC_KHZ) - pll_in_khz * 32'(pll_div)) < 32'(pll_div))
            && (pll_out_khz == 32'(pll_in_khz * (32'(pll_mul) + 32'h1))))
        else $error("PLL output is not input divided then multiplied");

    a_pll_lock_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (wr_pll && (next_pll_cfg[PLL_CNT_LSB +: PLL_CNT_W] != '0)) |=> ##1 !pll_lock)
        else $error("PLL lock did not drop after configuration write");

    a_mck_write_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_mck |=> !mck_ready ##1 !mck_ready)
        else $error("ready flag not cleared by master clock write");

    a_mck_ready_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(mck_ready) |-> $past(sw_state) == SW_SYNC_NEW && o_mck_source == $past(req_src))
        else $error("ready flag rose without applying the new setting");

    a_glitch_free_sw: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $changed(o_mck_source) |-> $past(sw_apply) && mck_ready)
        else $error("master clock source changed outside the synced step");

endmodule : clk_manager

// ===== test_clk_manager.sv
// Self-checking bench for the clock manager registers and clock sequencing
`timescale 1ns/100ps
module test_clk_manager
    import clk_mgr_pkg::*;
;
    // Small tick keeps every startup count used here to at most 144 cycles
    localparam int T = 6;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h00000000;
    logic [3:0] i_byteenable = 4'hf;
    logic [31:0] o_readdata, o_mck_khz;
    logic o_waitrequest, o_osc_enable, o_pll_enable, o_irq;
    logic [PLL_DIV_W-1:0] o_pll_div;
    logic [PLL_MUL_W-1:0] o_pll_mul;
    logic [MCK_SRC_W-1:0] o_mck_source;
    logic [MCK_CLOCK_PRESCALER_FIELD_W-1:0] o_mck_prescaler;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h89afc616;
    logic [31:0] q;
    int n, t0, dv, ml, pc, pll_khz;

    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) cyc <= cyc + 1;

    clk_manager #(.TICK_CYCLES(T), .OSC_KHZ(MAIN_OSC_KHZ)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_osc_enable(o_osc_enable),
        .o_pll_enable(o_pll_enable), .o_pll_div(o_pll_div), .o_pll_mul(o_pll_mul),
        .o_mck_source(o_mck_source), .o_mck_prescaler(o_mck_prescaler),
        .o_mck_khz(o_mck_khz), .o_irq(o_irq)
    );

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic timed_out(input string what);
        bad_count++;
        $display("MISMATCH %s expected answer seen none", what);
        tally_and_finish();
    endtask : timed_out

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        @(posedge i_clk_sys);
        i_address <= a;
        i_read <= rd;
        i_write <= !rd;
        i_writedata <= d;
        i_byteenable <= be;
        k = 0;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_waitrequest !== 1'b0 && k < 100);
        if (k >= 100) timed_out("waitrequest");
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask : wr

    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h00000000, 4'hf);
        check(name, q, exp);
    endtask : rd_chk

    task automatic wait_bit(input int b, input logic v);
        int k;
        for (k = 0; k < 400; k++) begin
            bus(1'b1, ADDR_STATUS, 32'h00000000, 4'hf);
            if (q[b] === v) break;
        end
        if (k >= 400) timed_out("status bit");
    endtask : wait_bit

    task automatic reset_dut();
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        check("mck_source", o_mck_source, SRC_SLOW);
        check("mck_khz", o_mck_khz, SLOW_CLK_KHZ);
        check("osc_enable", o_osc_enable, 0);
        rd_chk("status", ADDR_STATUS, 32'h00000008);
    endtask : reset_dut

    // Master clock write: ready drops, old source holds, then both apply
    task automatic mck_set(input logic [31:0] v, input logic [1:0] src, input int khz);
        logic [1:0] old_src;
        old_src = o_mck_source;
        wr(ADDR_MCK_CFG, v);
        bus(1'b1, ADDR_STATUS, 32'h00000000, 4'hf);
        check("ready low", q[ST_MASTER_CLOCK_READY_FLAG_BIT], 1'b0);
        check("src held", o_mck_source, old_src);
        wait_bit(ST_MASTER_CLOCK_READY_FLAG_BIT, 1'b1);
        check("mck_source", o_mck_source, src);
        check("prescaler", o_mck_prescaler, v[4:2]);
        check("mck_khz", o_mck_khz, khz >> v[4:2]);
        rd_chk("mck readback", ADDR_MCK_CFG, v);
    endtask : mck_set

    initial begin
        repeat (100000) @(posedge i_clk_sys);
        timed_out("run");
    end

    initial begin
        reset_dut();
        foreach (q[i]) if (i < 3) rd_chk("reg reset", 5'(i * 4), 32'h00000000);
        rd_chk("status reset", ADDR_STATUS, 32'h00000008);
        rd_chk("mask reset", ADDR_INT_MASK, INT_MASK_RST);
        wr(5'h18, 32'hffffffff);
        rd_chk("unmapped", 5'h18, 32'h00000000);
        wr(ADDR_STATUS, 32'h00000000);
        rd_chk("status ro", ADDR_STATUS, 32'h00000008);
        $display("test reset and map done");

        n = 1 + xorshift() % 3;
        wr(ADDR_OSC_CTRL, (n << 8) | 1);
        t0 = cyc;
        // Control outputs follow the register image one cycle later
        repeat (2) @(posedge i_clk_sys);
        check("osc_enable", o_osc_enable, 1);
        rd_chk("osc readback", ADDR_OSC_CTRL, (n << 8) | 1);
        rd_chk("not stable", ADDR_STATUS, 32'h00000008);
        wait_bit(ST_OSC_BIT, 1'b1);
        check("osc time lo", (cyc - t0) >= n * 8 * T - T, 1);
        check("osc time hi", (cyc - t0) <= n * 8 * T + T + 8, 1);
        $display("test oscillator done");

        mck_set({27'h0, 3'h0, SRC_MAIN}, SRC_MAIN, MAIN_OSC_KHZ);
        $display("test main switch done");

        dv = 1 + xorshift() % 15;
        ml = 1 + xorshift() % 120;
        pc = 3 + xorshift() % 4;
        pll_khz = (MAIN_OSC_KHZ / dv) * (ml + 1);
        wr(ADDR_PLL_CFG, (ml << 16) | (pc << 8) | dv);
        t0 = cyc;
        repeat (2) @(posedge i_clk_sys);
        check("pll_div", o_pll_div, dv);
        check("pll_mul", o_pll_mul, ml);
        check("pll_enable", o_pll_enable, 1);
        rd_chk("pll readback", ADDR_PLL_CFG, (ml << 16) | (pc << 8) | dv);
        rd_chk("not locked", ADDR_STATUS, 32'h00000009);
        wait_bit(ST_LOCK_BIT, 1'b1);
        check("lock time", (cyc - t0) <= pc * T + T + 8, 1);
        $display("test pll done");

        mck_set({27'h0, 3'h1, SRC_MAIN}, SRC_MAIN, MAIN_OSC_KHZ);
        mck_set({27'h0, 3'h1, SRC_PLL}, SRC_PLL, pll_khz);
        mck_set({27'h0, 3'h0, 2'h3}, 2'h3, pll_khz);
        for (int p = 0; p < 8; p++) mck_set(32'(p << 2), SRC_SLOW, SLOW_CLK_KHZ);
        $display("test prescaler and source done");

        rd_chk("events", ADDR_INT_STATUS, INT_BITS_MASK);
        check("irq masked", o_irq, 0);
        bus(1'b0, ADDR_INT_MASK, 32'h0000000f, 4'h0);
        rd_chk("mask no lanes", ADDR_INT_MASK, 32'h00000000);
        wr(ADDR_INT_MASK, 32'h00000002);
        repeat (2) @(posedge i_clk_sys);
        check("irq raised", o_irq, 1);
        wr(ADDR_INT_STATUS, 32'h00000002);
        repeat (2) @(posedge i_clk_sys);
        check("irq cleared", o_irq, 0);
        rd_chk("w1c", ADDR_INT_STATUS, 32'h00000009);
        wr(ADDR_INT_STATUS, 32'h00000008);
        wr(ADDR_INT_MASK, 32'h00000008);
        mck_set(32'h00000000, SRC_SLOW, SLOW_CLK_KHZ);
        repeat (2) @(posedge i_clk_sys);
        check("irq ready event", o_irq, 1);
        $display("test interrupt done");

        reset_dut();
        check("irq after reset", o_irq, 0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : test_clk_manager
